// >>> msc_defs.vh
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH
// Security byte window in nonvolatile memory
`define MSC_SEC_FIRST_ADDR 16'hFFF6
`define MSC_SEC_LAST_ADDR 16'hFFFD
`define MSC_SEC_COUNT 4'h8
// Blank (erased) value of a memory byte
`define MSC_BLANK_BYTE 8'hFF
// Value returned for locked reads
`define MSC_INVALID_BYTE 8'h00
// Status location in RAM and its pass bit
`define MSC_STATUS_ADDR 8'h80
`define MSC_STATUS_BIT 6
// Serial timing: 20 MHz clock, bit time in ns
`define MSC_CLK_NS 50
`define MSC_BIT_NS 2000
`define MSC_BIT_CYCLES (`MSC_BIT_NS / `MSC_CLK_NS)
// Break character: low bits sent then stop
`define MSC_BREAK_BITS 4'hA
// Nonvolatile memory address range (upper 4 KB)
`define MSC_NVM_BASE 16'hF000
`define MSC_NVM_BASE_HI 4'hF
`endif

// >>> msc_fifo.v
`timescale 1ns/1ns
module msc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output reg outValid_r,
  input wire outReady,
  output reg [WIDTH-1:0] outData_r
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_r;
  reg [AW:0] rdPtr_r;
  wire full;
  wire empty;
  wire doWrite;
  wire doRead;

  assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign empty = (wrPtr_r == rdPtr_r);
  assign inReady = !full;
  assign doWrite = inValid && !full;
  // Output register refills when empty or being taken
  assign doRead = !empty && (!outValid_r || outReady);

  always @(posedge ref_clk) begin
    if (doWrite) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= {(AW+1){1'b0}};
      rdPtr_r <= {(AW+1){1'b0}};
      outValid_r <= 1'b0;
      outData_r <= {WIDTH{1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRead) begin
        rdPtr_r <= rdPtr_r + 1'b1;
        outData_r <= mem[rdPtr_r[AW-1:0]];
        outValid_r <= 1'b1;
      end else if (outReady) begin
        outValid_r <= 1'b0;
      end
    end
  end
endmodule // msc_fifo

// >>> msc_gate.v
`timescale 1ns/1ns
`include "msc_defs.vh"
// Functional notes
// RULE_01: Host sends eight bytes; unlock only if all equal the stored security bytes.
// RULE_02: After power-on with monitor mode, wait for security bytes before anything.
// RULE_03: On full match, allow all memory reads and code execution from memory.
// RULE_04: Bypass, once granted, holds until the next power-on reset.
// RULE_05: Other resets keep existing bypass; no new security bytes needed.
// RULE_06: On mismatch stay in monitor mode; memory reads return an invalid value.
// RULE_07: Without bypass, code fetch from memory raises an illegal address reset.
// RULE_08: Break character is sent only after all eight bytes are received; with bypass, a warm restart sends it with no bytes received.
// RULE_09: Pass flag goes to status bit of the fixed RAM location.
// RULE_10: After failure the host must power-cycle and re-enter monitor mode.
// RULE_11: Mass erase leaves every security location blank.
// RULE_12: User should program all eight security locations.
// RULE_13: Compare bytes in arrival order against ascending stored addresses.
module msc_gate #(
  parameter BIT_CYCLES = `MSC_BIT_CYCLES,
  parameter FIFO_DEPTH = 32
) (
  // Clock and resets
  input wire ref_clk,
  input wire resetn,
  input wire porResetn,
  // Mode and serial link
  input wire monitorMode,
  input wire monSerialIn,
  output reg monSerialOut_r,
  output reg monSerialOe_r,
  // Security byte fetch from memory
  output reg [15:0] secAddr_r,
  input wire [7:0] secData,
  // CPU access to memory
  input wire cpuReq,
  input wire cpuFetch,
  input wire [15:0] cpuAddr,
  input wire [7:0] memData,
  output reg [7:0] cpuData_r,
  output reg cpuAck_r,
  output reg illegalAddrReset_r,
  // Status to RAM and core
  output reg statusWrite_r,
  output reg [7:0] statusAddr_r,
  output reg [7:0] statusData_r,
  output reg secDone_r,
  output reg bypass_r,
  output reg cmdValid_r,
  output reg [7:0] cmdData_r,
  input wire cmdReady
);
  // One-hot sequencer states
  localparam S_WAIT = 5'h01;
  localparam S_CMP = 5'h02;
  localparam S_STAT = 5'h04;
  localparam S_BRK = 5'h08;
  localparam S_RUN = 5'h10;
  localparam CW = 16;

  // Pointer width follows the FIFO depth, so the two cannot drift apart
  function integer addrBits;
    input integer depth;
    integer w;
    begin
      w = 0;
      while ((1 << w) < depth) begin
        w = w + 1;
      end
      addrBits = w;
    end
  endfunction
  localparam FIFO_AW = addrBits(FIFO_DEPTH);

  // Pin synchronisers
  reg rxMeta_r;
  reg rxSync_r;
  reg rxPrev_r;
  // Receiver
  reg rxBusy_r;
  reg rxHalf_r;
  reg [CW-1:0] rxCnt_r;
  reg [3:0] rxBit_r;
  reg [7:0] rxShift_r;
  reg rxValid_r;
  // Byte stream through FIFO
  wire fifoOutValid;
  wire [7:0] fifoOutData;
  reg fifoTake;
  // Sequencer
  reg [4:0] state_r;
  reg [3:0] byteIdx_r;
  reg mismatch_r;
  reg [CW-1:0] txCnt_r;
  reg [3:0] txBit_r;
  reg bypassArmed_r;
  // Pass outcome, shared by the bypass arm and the status byte
  wire passNow;

  function inNvm;
    input [15:0] a;
    begin
      inNvm = (a[15:12] == `MSC_NVM_BASE_HI);
    end
  endfunction

  function [7:0] statusByte;
    input pass;
    begin
      statusByte = 8'h00;
      statusByte[`MSC_STATUS_BIT] = pass;
    end
  endfunction

  // A warm restart with bypass already granted reports a pass
  assign passNow = !mismatch_r || bypass_r;

  // Line idles high, so the synchroniser resets high to avoid a false start
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else begin
      rxMeta_r <= monSerialIn;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
    end
  end

  // 8N1 receiver: start bit confirmed at mid-bit, data sampled mid-bit
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rxBusy_r <= 1'b0;
      rxHalf_r <= 1'b0;
      rxCnt_r <= {CW{1'b0}};
      rxBit_r <= 4'h0;
      rxShift_r <= 8'h00;
      rxValid_r <= 1'b0;
    end else begin
      rxValid_r <= 1'b0;
      if (!rxBusy_r) begin
        if (rxPrev_r && !rxSync_r) begin
          rxBusy_r <= 1'b1;
          rxHalf_r <= 1'b1;
          rxCnt_r <= BIT_CYCLES[CW-1:0] >> 1;
          rxBit_r <= 4'h0;
        end
      end else if (rxCnt_r != {CW{1'b0}}) begin
        rxCnt_r <= rxCnt_r - 1'b1;
      end else if (rxHalf_r) begin
        rxHalf_r <= 1'b0;
        // A glitch shorter than half a bit is not taken for a start bit
        if (rxSync_r) begin
          rxBusy_r <= 1'b0;
        end else begin
          rxCnt_r <= BIT_CYCLES[CW-1:0] - 1'b1;
        end
      end else if (rxBit_r == 4'h8) begin
        rxBusy_r <= 1'b0;
        // Only well-framed bytes are kept
        rxValid_r <= rxSync_r;
      end else begin
        rxShift_r <= {rxSync_r, rxShift_r[7:1]};
        rxBit_r <= rxBit_r + 1'b1;
        rxCnt_r <= BIT_CYCLES[CW-1:0] - 1'b1;
      end
    end
  end

  // Bytes dropped if the FIFO is full; the host paces one byte at a time
  msc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) uFifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .inValid(rxValid_r),
    .inReady(),
    .inData(rxShift_r),
    .outValid_r(fifoOutValid),
    .outReady(fifoTake),
    .outData_r(fifoOutData)
  );

  always @* begin
    fifoTake = 1'b0;
    case (state_r)
      S_CMP: fifoTake = fifoOutValid;
      S_RUN: fifoTake = fifoOutValid && (!cmdValid_r || cmdReady);
      default: fifoTake = 1'b0;
    endcase
  end

  // Bypass lives on the power-on reset only, so other resets keep it
  always @(posedge ref_clk or negedge porResetn) begin
    if (!porResetn) begin
      bypass_r <= 1'b0;
    end else if (bypassArmed_r) begin
      bypass_r <= 1'b1; // [RULE_04] [RULE_05]
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_WAIT;
      byteIdx_r <= 4'h0;
      mismatch_r <= 1'b0;
      secAddr_r <= `MSC_SEC_FIRST_ADDR;
      txCnt_r <= {CW{1'b0}};
      txBit_r <= 4'h0;
      bypassArmed_r <= 1'b0;
      monSerialOut_r <= 1'b1;
      monSerialOe_r <= 1'b0;
      statusWrite_r <= 1'b0;
      statusAddr_r <= `MSC_STATUS_ADDR;
      statusData_r <= 8'h00;
      secDone_r <= 1'b0;
      cmdValid_r <= 1'b0;
      cmdData_r <= 8'h00;
    end else begin
      statusWrite_r <= 1'b0;
      bypassArmed_r <= 1'b0;
      if (cmdValid_r && cmdReady) begin
        cmdValid_r <= 1'b0;
      end
      case (state_r)
        // Without bypass, nothing happens until monitor mode is seen; early bytes wait in the FIFO
        S_WAIT: begin
          if (bypass_r) begin
            state_r <= S_STAT; // [RULE_05]
          end else if (monitorMode) begin
            state_r <= S_CMP; // [RULE_02]
            byteIdx_r <= 4'h0;
            mismatch_r <= 1'b0;
            secAddr_r <= `MSC_SEC_FIRST_ADDR;
          end
        end
        S_CMP: begin
          if (fifoOutValid) begin
            // Blank locations are compared like any programmed byte
            if (fifoOutData != secData) begin
              mismatch_r <= 1'b1; // [RULE_13] [RULE_01] [RULE_11]
            end
            secAddr_r <= secAddr_r + 16'h0001; // [RULE_13]
            byteIdx_r <= byteIdx_r + 1'b1;
            if (byteIdx_r == `MSC_SEC_COUNT - 4'h1) begin
              state_r <= S_STAT;
            end
          end
        end
        S_STAT: begin
          if (passNow) begin
            bypassArmed_r <= 1'b1; // [RULE_03]
          end
          statusWrite_r <= 1'b1;
          statusData_r <= statusByte(passNow); // [RULE_09]
          // Break holds the pin low for ten bit times, then lets it go
          txCnt_r <= BIT_CYCLES[CW-1:0] - 1'b1;
          txBit_r <= 4'h0;
          monSerialOe_r <= 1'b1;
          monSerialOut_r <= 1'b0;
          state_r <= S_BRK; // [RULE_08]
        end
        S_BRK: begin
          if (txCnt_r != {CW{1'b0}}) begin
            txCnt_r <= txCnt_r - 1'b1;
          end else if (txBit_r == `MSC_BREAK_BITS - 4'h1) begin
            monSerialOut_r <= 1'b1;
            monSerialOe_r <= 1'b0;
            secDone_r <= 1'b1;
            state_r <= S_RUN;
          end else begin
            txBit_r <= txBit_r + 1'b1;
            txCnt_r <= BIT_CYCLES[CW-1:0] - 1'b1;
          end
        end
        S_RUN: begin
          if (fifoTake) begin
            cmdValid_r <= 1'b1;
            cmdData_r <= fifoOutData;
          end
        end
        default: state_r <= S_WAIT;
      endcase
    end
  end

  // Memory access gate
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpuData_r <= 8'h00;
      cpuAck_r <= 1'b0;
      illegalAddrReset_r <= 1'b0;
    end else begin
      // Only data reads are acknowledged; a locked fetch answers with the reset
      cpuAck_r <= cpuReq && !cpuFetch;
      illegalAddrReset_r <= 1'b0;
      if (cpuReq && inNvm(cpuAddr) && !bypass_r) begin
        cpuData_r <= `MSC_INVALID_BYTE; // [RULE_06]
        illegalAddrReset_r <= cpuFetch; // [RULE_07]
      end else if (cpuReq) begin
        cpuData_r <= memData; // [RULE_03]
      end
    end
  end
endmodule // msc_gate

// >>> msc_gate_assertions.sv
`timescale 1ns/1ns
module msc_gate_chk (
  // Clock and resets
  input wire ref_clk,
  input wire resetn,
  input wire porResetn,
  // Serial pin
  input wire monSerialOut_r,
  input wire monSerialOe_r,
  // CPU side
  input wire cpuReq,
  input wire cpuFetch,
  input wire [15:0] cpuAddr,
  input wire [7:0] memData,
  input wire [7:0] cpuData_r,
  input wire cpuAck_r,
  input wire illegalAddrReset_r,
  // Status
  input wire statusWrite_r,
  input wire [7:0] statusAddr_r,
  input wire secDone_r,
  input wire bypass_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  brk_low_a:
    assert property (monSerialOe_r |-> !monSerialOut_r) else $error("break level high");
  done_idle_a:
    assert property ($rose(secDone_r) |-> !monSerialOe_r && monSerialOut_r) else $error("pin busy");
  lock_rd_a:
    assert property (cpuReq && !cpuFetch && !bypass_r && cpuAddr[15:12] == 4'hF
      |=> cpuAck_r && cpuData_r == 8'h00) else $error("locked read leaked");
  open_rd_a:
    assert property (cpuReq && !cpuFetch && bypass_r |=> cpuData_r == $past(memData))
      else $error("open read wrong");
  lock_exec_a:
    assert property (cpuReq && cpuFetch && !bypass_r && cpuAddr[15:12] == 4'hF
      |=> illegalAddrReset_r) else $error("locked fetch not reset");
  open_exec_a:
    assert property (cpuReq && cpuFetch && bypass_r |=> !illegalAddrReset_r)
      else $error("open fetch reset");
  bypass_hold_a:
    assert property (disable iff (!porResetn) bypass_r |=> bypass_r) else $error("bypass lost");
  stat_addr_a:
    assert property (statusWrite_r |-> statusAddr_r == 8'h80) else $error("status address");
endmodule // msc_gate_chk
bind msc_gate msc_gate_chk i_chk (.ref_clk(ref_clk), .resetn(resetn), .porResetn(porResetn),
  .monSerialOut_r(monSerialOut_r), .monSerialOe_r(monSerialOe_r), .cpuReq(cpuReq),
  .cpuFetch(cpuFetch), .cpuAddr(cpuAddr), .memData(memData), .cpuData_r(cpuData_r),
  .cpuAck_r(cpuAck_r), .illegalAddrReset_r(illegalAddrReset_r),
  .statusWrite_r(statusWrite_r), .statusAddr_r(statusAddr_r), .secDone_r(secDone_r),
  .bypass_r(bypass_r));

// >>> msc_host.sv
`timescale 1ns/1ns
module msc_host #(
  parameter BITC = 8
) (
  // Clock
  input wire ref_clk,
  // Line toward the device
  output reg txLine
);
  initial txLine = 1'b1;
  // One start, eight data LSB first, one stop; idle high between
  task sendByte(input [7:0] b, input integer gap);
    integer i;
    reg [9:0] frame;
    begin
      frame = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        @(posedge ref_clk);
        txLine <= frame[i];
        repeat (BITC - 1) @(posedge ref_clk);
      end
      repeat (gap) @(posedge ref_clk);
    end
  endtask
endmodule // msc_host

// >>> msc_gate_tb_top.sv
`timescale 1ns/1ns
module msc_gate_tb_top;
  localparam BITC = 8;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  reg porResetn = 1'b0;
  reg cpuReq = 1'b0;
  reg cpuFetch = 1'b0;
  reg [15:0] cpuAddr = 16'hF000;
  reg blank = 1'b0;
  reg [7:0] lastStat = 8'h00;
  reg monMode = 1'b1;
  integer n_errors = 0;
  integer tests_run = 0;
  wire hostTx, serOut, serOe, ack, ilad, stWr, done, byp, cmdV;
  wire [15:0] secAddr;
  wire [7:0] cpuData, stAddr, stData, cmdD;
  // Shared pin: device wins only while it drives the break
  wire serLine = serOe ? serOut : hostTx;
  // Security bytes programmed, or erased to blank
  wire [7:0] secData = blank ? 8'hFF : {4'hA, secAddr[3:0]};
  wire [7:0] memData = cpuAddr[7:0] ^ 8'h5A;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (stWr) lastStat <= stData;
  msc_host #(.BITC(BITC)) i_host (.ref_clk(ref_clk), .txLine(hostTx));
  msc_gate #(.BIT_CYCLES(BITC)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
    .porResetn(porResetn), .monitorMode(monMode), .monSerialIn(serLine),
    .monSerialOut_r(serOut), .monSerialOe_r(serOe), .secAddr_r(secAddr), .secData(secData),
    .cpuReq(cpuReq), .cpuFetch(cpuFetch), .cpuAddr(cpuAddr), .memData(memData),
    .cpuData_r(cpuData), .cpuAck_r(ack), .illegalAddrReset_r(ilad), .statusWrite_r(stWr),
    .statusAddr_r(stAddr), .statusData_r(stData), .secDone_r(done), .bypass_r(byp),
    .cmdValid_r(cmdV), .cmdData_r(cmdD), .cmdReady(1'b1));
  task check(input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      if (n_errors == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task doReset(input por);
    begin
      @(posedge ref_clk);
      resetn <= 1'b0;
      porResetn <= !por;
      lastStat <= 8'h00;
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      porResetn <= 1'b1;
    end
  endtask
  task cpuOp(input f, input [15:0] a);
    begin
      @(posedge ref_clk);
      cpuReq <= 1'b1;
      cpuFetch <= f;
      cpuAddr <= a;
      @(posedge ref_clk);
      cpuReq <= 1'b0;
      #1;
    end
  endtask
  // Sends nb key bytes, the last one flipped by badX, then judges the outcome
  task entry(input integer nb, input [7:0] badX, input expPass);
    integer i, k, brk;
    reg [7:0] key;
    begin
      for (i = 0; i < nb; i = i + 1) begin
        if (i == 7) check(serOe, 0);
        key = blank ? 8'hFF : 8'hA6 + i[7:0];
        i_host.sendByte(key ^ (i == 7 ? badX : 8'h00), i == 3 ? 5 : 0);
      end
      k = 0;
      brk = 0;
      while (!(done === 1'b1) && k < 2000) begin
        @(posedge ref_clk);
        if (serOe === 1'b1) brk = brk + 1;
        k = k + 1;
      end
      if (done !== 1'b1) begin
        n_errors = n_errors + 1;
      end else begin
        #1;
        check(byp, expPass);
        check(lastStat[6], expPass);
        check(brk, 10 * BITC);
        cpuOp(0, 16'hF123);
        check(cpuData, expPass ? 8'h79 : 8'h00);
        check(ack, 1);
        cpuOp(1, 16'hFFFE);
        check(ilad, !expPass);
        check(ack, 0);
      end
    end
  endtask
  // A byte sent after entry comes out as a command
  task cmdEcho(input [7:0] b);
    integer k;
    begin
      i_host.sendByte(b, 0);
      k = 0;
      while (!(cmdV === 1'b1) && k < 200) begin
        @(negedge ref_clk);
        k = k + 1;
      end
      check(cmdV, 1);
      check(cmdD, b);
    end
  endtask
  // Without monitor mode the key bytes are never judged and no break follows
  task scnNoMon;
    integer i;
    begin
      @(posedge ref_clk);
      monMode <= 1'b0;
      doReset(1);
      for (i = 0; i < 8; i = i + 1) begin
        i_host.sendByte(8'hA6 + i[7:0], 0);
      end
      repeat (100) @(posedge ref_clk);
      #1;
      check(done, 0);
      check(serOe, 0);
      check(byp, 0);
      @(posedge ref_clk);
      monMode <= 1'b1;
    end
  endtask
  task scnFail;
    begin
      doReset(1);
      entry(8, 8'h01, 0);
    end
  endtask
  task scnPass;
    begin
      doReset(1);
      entry(8, 8'h00, 1);
      cmdEcho(8'h3C);
    end
  endtask
  task scnWarm;
    begin
      doReset(0);
      entry(0, 8'h00, 1);
    end
  endtask
  task scnBlank;
    begin
      @(posedge ref_clk);
      blank <= 1'b1;
      doReset(1);
      #1;
      check(byp, 0);
      entry(8, 8'h00, 1);
    end
  endtask
  initial begin
    scnNoMon;
    scnFail;
    scnPass;
    scnWarm;
    scnBlank;
    summarize;
  end
endmodule // msc_gate_tb_top
